// file: core/sid_pkg.sv
// constants and carriers of the identification byte page
package sid_pkg;

   // ----------------------------------------
   // carriers
   // ----------------------------------------
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [7:0] addr;
   } sid_req_type;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } sid_rsp_type;

   typedef enum logic [1:0] {
      SCAN_RUN,
      SCAN_CHECK,
      SCAN_DONE
   } sid_scan_type;

   // ----------------------------------------
   // byte addresses
   // ----------------------------------------
   localparam logic [7:0] ADDR_MIN_RATE   = 8'h8c;
   localparam logic [7:0] ADDR_MAX_RATE   = 8'h8d;
   localparam logic [7:0] ADDR_SM_KM      = 8'h8e;
   localparam logic [7:0] ADDR_EBW_REACH  = 8'h8f;
   localparam logic [7:0] ADDR_MM50_REACH = 8'h90;
   localparam logic [7:0] ADDR_MM62_REACH = 8'h91;
   localparam logic [7:0] ADDR_CU_REACH   = 8'h92;
   localparam logic [7:0] ADDR_DEV_TECH   = 8'h93;
   localparam logic [7:0] ADDR_NAME_FIRST = 8'h94;
   localparam logic [7:0] ADDR_NAME_LAST  = 8'ha3;
   localparam logic [7:0] ADDR_RCV_CAPS   = 8'ha4;
   localparam logic [7:0] ADDR_CID_FIRST  = 8'ha5;
   localparam logic [7:0] ADDR_CID_LAST   = 8'ha7;
   localparam logic [7:0] ADDR_PART_FIRST = 8'ha8;
   localparam logic [7:0] ADDR_PART_LAST  = 8'hb7;
   localparam logic [7:0] ADDR_REV_FIRST  = 8'hb8;
   localparam logic [7:0] ADDR_REV_LAST   = 8'hb9;
   localparam logic [7:0] ADDR_WAVE_HI    = 8'hba;
   localparam logic [7:0] ADDR_WAVE_LO    = 8'hbb;
   localparam logic [7:0] ADDR_TOL_HI     = 8'hbc;
   localparam logic [7:0] ADDR_TOL_LO     = 8'hbd;
   localparam logic [7:0] ADDR_CASE_TEMP  = 8'hbe;
   localparam logic [7:0] ADDR_CHECKSUM   = 8'hbf;
   localparam logic [7:0] ADDR_MAX_PWR    = 8'hc0;
   localparam logic [7:0] ADDR_PDN_PWR    = 8'hc1;
   localparam logic [7:0] ADDR_CUR_5V_3V3 = 8'hc2;
   localparam logic [7:0] ADDR_CUR_1V8_N5 = 8'hc3;
   localparam logic [7:0] CHK_FIRST       = 8'h80;
   localparam logic [7:0] CHK_LAST        = 8'hbe;

   // ----------------------------------------
   // field contents
   // ----------------------------------------
   localparam logic [7:0]   MIN_LINE_RATE    = 8'h63;
   localparam logic [7:0]   MAX_LINE_RATE    = 8'h6f;
   localparam logic [7:0]   SM_REACH_KM      = 8'h0a;
   localparam logic [7:0]   EBW_REACH        = 8'h00;
   localparam logic [7:0]   MM50_REACH       = 8'h00;
   localparam logic [7:0]   MM62_REACH       = 8'h00;
   localparam logic [7:0]   CU_REACH         = 8'h00;
   localparam logic [3:0]   TX_TECH          = 4'h4;
   localparam logic [3:0]   TX_COPPER_OTHER  = 4'h8;
   localparam logic [3:0]   TECH_FLAGS       = 4'h0;
   localparam logic [127:0] NAME_TEXT        = 128'h4558_414d_504c_4520_4f50_5449_4353_2020;
   localparam logic [7:0]   ASCII_SPACE      = 8'h20;
   localparam logic [7:0]   ASCII_LAST       = 8'h7e;
   localparam logic [7:0]   RCV_CAPS         = 8'hfb;
   // company identifier value is arbitrary
   localparam logic [23:0]  COMPANY_ID       = 24'h12_3456;
   localparam logic [127:0] PART_TEXT        = 128'h4558_414d_504c_452d_5041_5254_2d30_3120;
   localparam logic [15:0]  REV_TEXT         = 16'h4120;
   // centre of the guaranteed range, 1307.5 nm
   localparam logic [15:0]  WAVELENGTH       = 16'h6626;
   localparam logic [15:0]  WAVE_TOLERANCE   = 16'h251c;
   localparam logic [7:0]   CASE_TEMP        = 8'h46;
   localparam logic [7:0]   MAX_PWR          = 8'h7d;
   localparam logic [7:0]   PDN_PWR          = 8'h0a;
   localparam logic [7:0]   CUR_5V_3V3       = 8'h05;
   localparam logic [7:0]   CUR_1V8_N5       = 8'h30;
   localparam logic [7:0]   SCAN_CYCLES      = 8'h40;

endpackage

// file: core/sid_rom_fields.sv
// read-only identification field page with self check of its check code
`timescale 1ns/1ps

module sid_rom_fields
   import sid_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire sid_req_type i_req,
   output sid_rsp_type      o_rsp,
   output logic             o_wr_ignored,
   output logic             o_check_done,
   output logic             o_check_ok
);

   // ----------------------------------------
   // image of the page, one byte per address
   // ----------------------------------------
   // every field but the check code
   function automatic logic [7:0] sid_field_byte(input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      if (a >= ADDR_NAME_FIRST && a <= ADDR_NAME_LAST) begin
         r = 8'(NAME_TEXT >> (8 * (ADDR_NAME_LAST - a)));
      end else if (a >= ADDR_CID_FIRST && a <= ADDR_CID_LAST) begin
         r = 8'(COMPANY_ID >> (8 * (ADDR_CID_LAST - a)));
      end else if (a >= ADDR_PART_FIRST && a <= ADDR_PART_LAST) begin
         r = 8'(PART_TEXT >> (8 * (ADDR_PART_LAST - a)));
      end else if (a >= ADDR_REV_FIRST && a <= ADDR_REV_LAST) begin
         r = 8'(REV_TEXT >> (8 * (ADDR_REV_LAST - a)));
      end else begin
         unique case (a)
            ADDR_MIN_RATE:   r = MIN_LINE_RATE;
            ADDR_MAX_RATE:   r = MAX_LINE_RATE;
            ADDR_SM_KM:      r = SM_REACH_KM;
            ADDR_EBW_REACH:  r = EBW_REACH;
            ADDR_MM50_REACH: r = MM50_REACH;
            ADDR_MM62_REACH: r = MM62_REACH;
            ADDR_CU_REACH:   r = CU_REACH;
            ADDR_DEV_TECH:   r = {TX_TECH, TECH_FLAGS};
            ADDR_RCV_CAPS:   r = RCV_CAPS;
            ADDR_WAVE_HI:    r = WAVELENGTH[15:8];
            ADDR_WAVE_LO:    r = WAVELENGTH[7:0];
            ADDR_TOL_HI:     r = WAVE_TOLERANCE[15:8];
            ADDR_TOL_LO:     r = WAVE_TOLERANCE[7:0];
            ADDR_CASE_TEMP:  r = CASE_TEMP;
            ADDR_MAX_PWR:    r = MAX_PWR;
            ADDR_PDN_PWR:    r = PDN_PWR;
            ADDR_CUR_5V_3V3: r = CUR_5V_3V3;
            ADDR_CUR_1V8_N5: r = CUR_1V8_N5;
            default:         r = 8'h00;
         endcase
      end
      return r;
   endfunction

   // low eight bits of the sum over the base field span
   function automatic logic [7:0] sid_base_sum();
      logic [7:0] s;
      s = 8'h00;
      for (int i = CHK_FIRST; i <= CHK_LAST; i++) begin
         s = 8'(s + sid_field_byte(8'(i)));
      end
      return s;
   endfunction

   // whole page; check code kept apart so the sum never calls itself
   function automatic logic [7:0] sid_rom_byte(input logic [7:0] a);
      return (a == ADDR_CHECKSUM) ? sid_base_sum() : sid_field_byte(a);
   endfunction

   // ----------------------------------------
   // read port
   // ----------------------------------------
   sid_rsp_type rsp_reg;
   sid_rsp_type rsp_next;
   logic        wr_ign_reg;
   logic        wr_ign_next;

   always_comb begin
      rsp_next.valid = i_req.rd;
      rsp_next.data  = rsp_reg.data;
      if (i_req.rd) begin
         rsp_next.data = sid_rom_byte(i_req.addr);
      end
      // writes are flagged and dropped
      wr_ign_next = i_req.wr;
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         rsp_reg    <= '0;
         wr_ign_reg <= 1'b0;
      end else begin
         rsp_reg    <= rsp_next;
         wr_ign_reg <= wr_ign_next;
      end
   end

   assign o_rsp        = rsp_reg;
   assign o_wr_ignored = wr_ign_reg;

   // ----------------------------------------
   // check code self scan after reset
   // ----------------------------------------
   sid_scan_type scan_reg;
   sid_scan_type scan_next;
   logic [7:0]   idx_reg;
   logic [7:0]   idx_next;
   logic [7:0]   acc_reg;
   logic [7:0]   acc_next;
   logic         ok_reg;
   logic         ok_next;

   always_comb begin
      scan_next = scan_reg;
      idx_next  = idx_reg;
      acc_next  = acc_reg;
      ok_next   = ok_reg;
      unique case (scan_reg)
         SCAN_RUN: begin
            acc_next = 8'(acc_reg + sid_rom_byte(idx_reg));
            idx_next = 8'(idx_reg + 8'h01);
            if (idx_reg == CHK_LAST) begin
               scan_next = SCAN_CHECK;
            end
         end
         SCAN_CHECK: begin
            ok_next   = (acc_reg == sid_rom_byte(ADDR_CHECKSUM));
            scan_next = SCAN_DONE;
         end
         SCAN_DONE: begin
            scan_next = SCAN_DONE;
         end
         default: begin
            scan_next = SCAN_RUN;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         scan_reg <= SCAN_RUN;
         idx_reg  <= CHK_FIRST;
         acc_reg  <= 8'h00;
         ok_reg   <= 1'b0;
      end else begin
         scan_reg <= scan_next;
         idx_reg  <= idx_next;
         acc_reg  <= acc_next;
         ok_reg   <= ok_next;
      end
   end

   assign o_check_done = (scan_reg == SCAN_DONE);
   assign o_check_ok   = ok_reg;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (i_rst);

   logic [7:0] rd_addr;
   assign rd_addr = i_req.addr;

   read_image_a: assert property (
      i_req.rd |=> o_rsp.valid && o_rsp.data == sid_rom_byte($past(rd_addr)))
      else $error("read data differs from image");

   write_drop_a: assert property (
      i_req.wr && !i_req.rd |=> o_wr_ignored && !o_rsp.valid
         && $stable(o_rsp.data))
      else $error("write disturbed read port");

   rate_min_a: assert property (
      i_req.rd && rd_addr == 8'h8c |=> o_rsp.data == MIN_LINE_RATE)
      else $error("minimum rate byte wrong");

   rate_max_a: assert property (
      i_req.rd && rd_addr == 8'h8d |=> o_rsp.data == MAX_LINE_RATE)
      else $error("maximum rate byte wrong");

   sm_reach_a: assert property (
      i_req.rd && rd_addr == ADDR_SM_KM |=> o_rsp.data == SM_REACH_KM)
      else $error("single mode reach wrong");

   mm_reach_a: assert property (
      i_req.rd && (rd_addr == ADDR_MM50_REACH || rd_addr == ADDR_MM62_REACH)
      |=> o_rsp.data == ($past(rd_addr) == ADDR_MM50_REACH ? MM50_REACH : MM62_REACH))
      else $error("multimode reach wrong");

   cu_reach_a: assert property (
      i_req.rd && rd_addr == ADDR_CU_REACH |=> o_rsp.data == CU_REACH)
      else $error("copper reach wrong");

   tech_flags_a: assert property (
      i_req.rd && rd_addr == ADDR_DEV_TECH |=> o_rsp.data[3:0] == TECH_FLAGS)
      else $error("technology flags wrong");

   tech_kind_a: assert property (
      i_req.rd && rd_addr == ADDR_DEV_TECH |=> o_rsp.data[7:4] <= TX_COPPER_OTHER)
      else $error("reserved transmitter code");

   name_text_a: assert property (
      i_req.rd && rd_addr >= 8'h94 && rd_addr <= 8'ha3
      |=> o_rsp.data >= ASCII_SPACE && o_rsp.data <= ASCII_LAST)
      else $error("supplier name not ASCII");

   ident_valid_a: assert property (
      i_req.rd && rd_addr == ADDR_NAME_FIRST
      |=> o_rsp.data != ASCII_SPACE || COMPANY_ID != 24'h00_0000)
      else $error("no supplier identity");

   rcv_resv_a: assert property (
      i_req.rd && rd_addr == ADDR_RCV_CAPS |=> !o_rsp.data[2]
         && o_rsp.data[7:3] == RCV_CAPS[7:3])
      else $error("recovery rate byte wrong");

   loopback_a: assert property (
      i_req.rd && rd_addr == ADDR_RCV_CAPS |=> o_rsp.data[1:0] == RCV_CAPS[1:0])
      else $error("loopback bits wrong");

   company_id_a: assert property (
      i_req.rd && rd_addr == 8'ha5 |=> o_rsp.data == COMPANY_ID[23:16])
      else $error("company identifier order wrong");

   part_text_a: assert property (
      i_req.rd && rd_addr == ADDR_PART_FIRST |=> o_rsp.data == PART_TEXT[127:120])
      else $error("part number not left justified");

   rev_text_a: assert property (
      i_req.rd && rd_addr == ADDR_REV_LAST |=> o_rsp.data == REV_TEXT[7:0])
      else $error("version text wrong");

   wave_order_a: assert property (
      i_req.rd && rd_addr == 8'hba ##1 i_req.rd && rd_addr == 8'hbb
      |=> {$past(o_rsp.data), o_rsp.data} == WAVELENGTH)
      else $error("wavelength byte order wrong");

   tol_order_a: assert property (
      i_req.rd && rd_addr == 8'hbc ##1 i_req.rd && rd_addr == 8'hbd
      |=> {$past(o_rsp.data), o_rsp.data} == WAVE_TOLERANCE)
      else $error("tolerance byte order wrong");

   check_code_a: assert property (
      i_req.rd && rd_addr == 8'hbf |=> o_rsp.data == sid_base_sum())
      else $error("check code byte wrong");

   scan_time_a: assert property (
      scan_reg == SCAN_RUN && idx_reg == CHK_FIRST
      |-> ##64 o_check_done && o_check_ok)
      else $error("check code scan failed");

   power_a: assert property (
      i_req.rd && rd_addr == 8'hc0 |=> o_rsp.data == MAX_PWR)
      else $error("power byte wrong");

   pdn_power_a: assert property (
      i_req.rd && rd_addr == 8'hc1 |=> o_rsp.data == PDN_PWR)
      else $error("power-down byte wrong");

   supply_cur_a: assert property (
      i_req.rd && (rd_addr == 8'hc2 || rd_addr == 8'hc3)
      |=> o_rsp.data == ($past(rd_addr) == 8'hc2 ? CUR_5V_3V3 : CUR_1V8_N5))
      else $error("supply current byte wrong");

   valid_pulse_a: assert property (
      !i_req.rd |=> !o_rsp.valid)
      else $error("answer without read");

   data_hold_a: assert property (
      !i_req.rd |=> $stable(o_rsp.data))
      else $error("read data changed without read");

   unmapped_a: assert property (
      i_req.rd && (rd_addr < ADDR_MIN_RATE || rd_addr > ADDR_CUR_1V8_N5) |=> o_rsp.data == 8'h00)
      else $error("unmapped byte not zero");

   company_last_a: assert property (
      i_req.rd && rd_addr == 8'ha7 |=> o_rsp.data == COMPANY_ID[7:0])
      else $error("company identifier end wrong");

   name_first_a: assert property (
      i_req.rd && rd_addr == 8'h94 |=> o_rsp.data == NAME_TEXT[127:120])
      else $error("supplier name start wrong");

   done_hold_a: assert property (
      o_check_done |=> o_check_done && $stable(o_check_ok))
      else $error("scan result not held");

endmodule // sid_rom_fields

// file: verif/sid_host_model.sv
// host controller model issuing byte requests to the identification page
`timescale 1ns/1ps

module sid_host_model
   import sid_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire sid_rsp_type i_rsp,
   input  wire logic        i_wr_ignored,
   output sid_req_type      o_req
);

   initial o_req = '0;

   // ----------------------------------------
   // one request slot per falling edge
   // ----------------------------------------
   // answer returned belongs to the previous slot
   task automatic cycle(input logic rd, input logic wr, input logic [7:0] addr,
                        output sid_rsp_type rsp, output logic wig);
      @(negedge i_ref_clk);
      rsp = i_rsp;
      wig = i_wr_ignored;
      o_req.rd = rd;
      o_req.wr = wr;
      // idle address flips so a stale address never looks valid
      o_req.addr = (rd | wr) ? addr : ~o_req.addr;
   endtask

endmodule // sid_host_model

// file: verif/test_serial_id_rom_fields.sv
// self-checking bench of the identification field page
`timescale 1ns/1ps

module test_serial_id_rom_fields
   import sid_pkg::*;
;
   logic        i_ref_clk;
   logic        i_rst;
   sid_req_type req;
   sid_rsp_type rsp;
   logic        wr_ignored;
   logic        check_done;
   logic        check_ok;
   int          fails = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [7:0]  img [256];
   logic [7:0]  got [256];

   initial i_ref_clk = 1'b0;
   always #12.5 i_ref_clk = ~i_ref_clk;

   sid_rom_fields i_sid_rom_fields (
      .i_ref_clk    (i_ref_clk),
      .i_rst        (i_rst),
      .i_req        (req),
      .o_rsp        (rsp),
      .o_wr_ignored (wr_ignored),
      .o_check_done (check_done),
      .o_check_ok   (check_ok)
   );

   sid_host_model i_sid_host_model (
      .i_ref_clk    (i_ref_clk),
      .i_rsp        (rsp),
      .i_wr_ignored (wr_ignored),
      .o_req        (req)
   );

   // ----------------------------------------
   // reporting
   // ----------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] expv, input string what);
      num_checks++;
      if (seen !== expv) begin
         fails++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, expv);
      end
   endtask

   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fails++;
         conclude();
      end
   end

   // ----------------------------------------
   // expected page image
   // ----------------------------------------
   task automatic build_image();
      int         i;
      logic [7:0] s;
      for (i = 0; i < 256; i++) img[i] = 8'h00;
      img[140] = MIN_LINE_RATE;
      img[141] = MAX_LINE_RATE;
      img[142] = SM_REACH_KM;
      img[143] = EBW_REACH;
      img[144] = MM50_REACH;
      img[145] = MM62_REACH;
      img[146] = CU_REACH;
      img[147] = {TX_TECH, TECH_FLAGS};
      img[164] = RCV_CAPS;
      img[186] = WAVELENGTH[15:8];
      img[187] = WAVELENGTH[7:0];
      img[188] = WAVE_TOLERANCE[15:8];
      img[189] = WAVE_TOLERANCE[7:0];
      img[190] = CASE_TEMP;
      img[192] = MAX_PWR;
      img[193] = PDN_PWR;
      img[194] = CUR_5V_3V3;
      img[195] = CUR_1V8_N5;
      for (i = 0; i < 16; i++) begin
         img[148 + i] = NAME_TEXT[127 - 8 * i -: 8];
         img[168 + i] = PART_TEXT[127 - 8 * i -: 8];
      end
      for (i = 0; i < 3; i++) img[165 + i] = COMPANY_ID[23 - 8 * i -: 8];
      for (i = 0; i < 2; i++) img[184 + i] = REV_TEXT[15 - 8 * i -: 8];
      s = 8'h00;
      for (i = 128; i <= 190; i++) s = 8'(s + img[i]);
      img[191] = s;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset(input int hold);
      int k;
      @(negedge i_ref_clk);
      i_rst = 1'b1;
      repeat (hold) @(negedge i_ref_clk);
      check(16'({rsp.valid, wr_ignored, check_done, check_ok}), 16'h0000, "outputs in reset");
      i_rst = 1'b0;
      for (k = 0; k < 63; k++) @(negedge i_ref_clk);
      check(16'({check_done, check_ok}), 16'h0000, "scan finished early");
      @(negedge i_ref_clk);
      check(16'({check_done, check_ok}), 16'h0003, "scan result");
      $display("test_reset done");
   endtask

   // every address read back to back
   task automatic test_fields();
      int          a;
      logic [7:0]  s;
      sid_rsp_type r;
      logic        w;
      for (a = 0; a <= 256; a++) begin
         i_sid_host_model.cycle(a < 256, 1'b0, 8'(a), r, w);
         if (a > 0) begin
            got[a - 1] = r.data;
            check(16'(r.valid), 16'h0001, "read answer");
            check(16'(r.data), 16'(img[a - 1]), "page byte");
         end
      end
      i_sid_host_model.cycle(1'b0, 1'b0, 8'h00, r, w);
      check(16'({r.valid, r.data}), 16'(img[255]), "valid one cycle, data held");
      check(16'(got[147][7:4] <= 4'h8), 16'h0001, "transmitter code");
      check(16'({got[186], got[187]}), 16'((16'h04ec + 16'h054b) * 16'h000a), "wavelength centre");
      check(16'(got[164][2]), 16'h0000, "reserved rate bit");
      check(16'(got[148] != ASCII_SPACE), 16'h0001, "name left justified");
      for (a = 148; a <= 163; a++) begin
         check(16'(got[a] >= ASCII_SPACE && got[a] <= ASCII_LAST), 16'h0001, "name printable");
      end
      check(16'(got[148] != 8'h00 || {got[165], got[166], got[167]} != 24'h00_0000), 16'h0001, "supplier id");
      s = 8'h00;
      for (a = 128; a <= 190; a++) s = 8'(s + got[a]);
      check(16'(got[191]), 16'(s), "check code");
      $display("test_fields done");
   endtask

   // writes to every address, reads alongside on even ones
   task automatic test_writes();
      int          a;
      int          last;
      logic        prev_rd;
      sid_rsp_type r;
      logic        w;
      last = 255;
      prev_rd = 1'b0;
      for (a = 0; a <= 256; a++) begin
         i_sid_host_model.cycle(a < 256 && a % 2 == 0, a < 256, 8'(a), r, w);
         if (a > 0) begin
            if (prev_rd) last = a - 1;
            check(16'(w), 16'h0001, "write flagged");
            check(16'({r.valid, r.data}), 16'({prev_rd, img[last]}), "answer beside write");
         end
         prev_rd = (a % 2 == 0);
      end
      i_sid_host_model.cycle(1'b0, 1'b0, 8'h00, r, w);
      check(16'({w, r.valid}), 16'h0000, "write flag one cycle");
      $display("test_writes done");
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      i_rst = 1'b1;
      build_image();
      test_reset(12);
      test_fields();
      test_writes();
      test_fields();
      test_reset(2);
      conclude();
   end

endmodule // test_serial_id_rom_fields
